// ### rtl/tpp_port.v
/*
 TDM PCM port: two serial input and two serial output streams, frame format
 detection, output drive gating, standby and initialization after reset.
 Assumes the bit clock and frame pulse come from an asynchronous backplane and
 that CLK_I runs well above twice the bit clock.
*/
`timescale 1ns/100ps
`include "tpp_defines.vh"

// What this block does
// R01: Both serial outputs are driven only when the drive enable pin and control bit 6 are high.
// R02: If either the pin or the control bit is low both serial outputs are released.
// R03: Receive input and send output form port 1, send input and receive output form port 2.
// R04: Each serial output carries 32 timeslots per frame at 2.048 Mbps.
// R05: Each serial input carries 32 timeslots per frame; only the timeslot selected at register 4 or 5 is received.
// R06: The frame pulse polarity format is detected without any configuration.
// R07: The far end supplies a 4.096 MHz bit clock that shifts all four streams.
// R08: The frequency select pin is synchronised and only reported at status register bit 4; no master clock is used.
// R09: Bit clock and frame pulse are asynchronous to CLK_I and are synchronised.
// R10: While reset is low the block is held in reset and in standby.
// R11: After reset release initialization presets the control register to its reset value.
// R12: Each 8-bit timeslot spans eight bits of two bit-clock cycles each, slot 0 after the pulse.
module tpp_port #(
    parameter CHANNELS = `TPP_CHANNELS,
    parameter INIT_CYCLES = `TPP_INIT_CYCLES
) (
    // Clock and reset
    input wire CLK_I,
    input wire RST_N_I,
    // Serial link
    input wire SERIAL_BIT_CLOCK_IN_I,
    input wire FRAME_PULSE_IN_I,
    input wire RIN_I,
    input wire SIN_I,
    input wire OUTPUT_DRIVE_ENABLE_I,
    input wire FREQ_SELECT_I,
    output reg SOUT_O,
    output reg SOUT_OE_O,
    output reg ROUT_O,
    output reg ROUT_OE_O,
    // Register port
    input wire [3:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [7:0] RDATA_O,
    // Status
    output reg STANDBY_O,
    output reg READY_O
);
    localparam ST_INIT = 2'h0;
    localparam ST_RUN = 2'h1;

    reg [2:0] clk_sync_reg;
    reg [1:0] fp_sync_reg;
    reg [1:0] rin_sync_reg;
    reg [1:0] sin_sync_reg;
    reg [1:0] ode_sync_reg;
    reg [1:0] fsel_sync_reg;
    reg [1:0] state_reg;
    reg [7:0] init_cnt_reg;
    reg [7:0] ctrl_reg;
    reg fmt_low_reg;
    reg fmt_valid_reg;
    reg fmt_seen_reg;
    reg fp_seen_reg;
    reg [4:0] slot_reg;
    reg [2:0] bit_reg;
    reg half_reg;
    reg [4:0] out_slot0_reg;
    reg [4:0] out_slot1_reg;
    reg [7:0] out0_data_reg;
    reg [7:0] out1_data_reg;
    reg [7:0] in0_data_reg;
    reg [7:0] in1_data_reg;
    reg [7:0] rx0_sh_reg;
    reg [7:0] rx1_sh_reg;
    reg [7:0] tx0_sh_reg;
    reg [7:0] tx1_sh_reg;
    reg [7:0] rd_next;
    reg [4:0] slot_next;
    wire clk_rise;
    wire clk_fall;
    wire fp_act;
    wire run;
    wire drive_en;

    // Link signals sampled twice before use
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            clk_sync_reg <= 3'h0;
            fp_sync_reg <= 2'h3;
            rin_sync_reg <= 2'h0;
            sin_sync_reg <= 2'h0;
            ode_sync_reg <= 2'h0;
            fsel_sync_reg <= 2'h0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[1:0], SERIAL_BIT_CLOCK_IN_I}; // R09
            fp_sync_reg <= {fp_sync_reg[0], FRAME_PULSE_IN_I}; // R09
            rin_sync_reg <= {rin_sync_reg[0], RIN_I};
            sin_sync_reg <= {sin_sync_reg[0], SIN_I};
            ode_sync_reg <= {ode_sync_reg[0], OUTPUT_DRIVE_ENABLE_I};
            fsel_sync_reg <= {fsel_sync_reg[0], FREQ_SELECT_I};
        end
    end

    assign clk_rise = clk_sync_reg[1] & ~clk_sync_reg[2]; // R07
    assign clk_fall = ~clk_sync_reg[1] & clk_sync_reg[2]; // R07
    // Pulse is active at the level opposite to the idle level seen
    assign fp_act = fmt_valid_reg & (fp_sync_reg[1] ^ ~fmt_low_reg); // R06
    assign run = (state_reg == ST_RUN);
    assign drive_en = run & ode_sync_reg[1] & ctrl_reg[`TPP_CTRL_ODE_BIT]; // R01 R02

    // Initialization and standby sequence
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= ST_INIT; // R10
            init_cnt_reg <= 8'h00;
        end else begin
            case (state_reg)
                ST_INIT: begin
                    if (init_cnt_reg == INIT_CYCLES[7:0] - 8'h01)
                        state_reg <= ST_RUN; // R11
                    else
                        init_cnt_reg <= init_cnt_reg + 8'h01;
                end
                ST_RUN: state_reg <= ST_RUN;
                default: state_reg <= ST_INIT;
            endcase
        end
    end

    // Frame format detection: idle level must match at two falls in a row,
    // as a pulse never spans two falls and may be present at the first one
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fmt_low_reg <= 1'b0;
            fmt_valid_reg <= 1'b0;
            fmt_seen_reg <= 1'b0;
        end else if (run && clk_fall && !fmt_valid_reg) begin
            fmt_low_reg <= ~fp_sync_reg[1]; // R06
            fmt_seen_reg <= 1'b1;
            if (fmt_seen_reg && (fmt_low_reg == ~fp_sync_reg[1]))
                fmt_valid_reg <= 1'b1; // R06
        end
    end

    // Bit and slot counters, two bit-clock cycles per bit
    always @* begin
        slot_next = slot_reg + 5'h01;
    end

    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            slot_reg <= 5'h00;
            bit_reg <= 3'h0;
            half_reg <= 1'b0;
            fp_seen_reg <= 1'b0;
            rx0_sh_reg <= 8'h00;
            rx1_sh_reg <= 8'h00;
            tx0_sh_reg <= 8'hff;
            tx1_sh_reg <= 8'hff;
            in0_data_reg <= 8'h00;
            in1_data_reg <= 8'h00;
        end else if (run && clk_fall) begin
            if (fp_act) begin
                fp_seen_reg <= 1'b1;
                slot_reg <= 5'h00; // R12
                bit_reg <= 3'h0;
                half_reg <= 1'b0;
                tx0_sh_reg <= (out_slot0_reg == 5'h00) ? out0_data_reg : 8'hff;
                tx1_sh_reg <= (out_slot1_reg == 5'h00) ? out1_data_reg : 8'hff;
            end else if (fp_seen_reg) begin
                half_reg <= ~half_reg;
                if (half_reg) begin
                    tx0_sh_reg <= {tx0_sh_reg[6:0], 1'b1}; // R04
                    tx1_sh_reg <= {tx1_sh_reg[6:0], 1'b1}; // R04
                    bit_reg <= bit_reg + 3'h1; // R12
                    if (bit_reg == 3'h7) begin
                        slot_reg <= (slot_reg == CHANNELS[4:0] - 5'h01) ? 5'h00 : slot_next;
                        tx0_sh_reg <= (out_slot0_reg == slot_next) ? out0_data_reg : 8'hff;
                        tx1_sh_reg <= (out_slot1_reg == slot_next) ? out1_data_reg : 8'hff;
                    end
                end
            end
        end else if (run && clk_rise && fp_seen_reg && half_reg) begin
            // Sample at the rise in the second bit-clock cycle of each bit, port 1 receive and port 2 send
            rx0_sh_reg <= {rx0_sh_reg[6:0], rin_sync_reg[1]}; // R03 R05
            rx1_sh_reg <= {rx1_sh_reg[6:0], sin_sync_reg[1]}; // R03 R05
            if (bit_reg == 3'h7) begin
                if (slot_reg == out_slot0_reg)
                    in0_data_reg <= {rx0_sh_reg[6:0], rin_sync_reg[1]};
                if (slot_reg == out_slot1_reg)
                    in1_data_reg <= {rx1_sh_reg[6:0], sin_sync_reg[1]};
            end
        end
    end

    // Register writes; initialization clears only the control register
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_reg <= `TPP_CTRL_RST;
            out0_data_reg <= 8'hff;
            out1_data_reg <= 8'hff;
            out_slot0_reg <= 5'h00;
            out_slot1_reg <= 5'h00;
        end else if (!run) begin
            ctrl_reg <= `TPP_CTRL_RST; // R11
        end else if (WR_I) begin
            case (ADDR_I)
                `TPP_CTRL_ADDR: ctrl_reg <= WDATA_I;
                `TPP_OUT0_ADDR: out0_data_reg <= WDATA_I;
                `TPP_OUT1_ADDR: out1_data_reg <= WDATA_I;
                `TPP_IN0_ADDR: out_slot0_reg <= WDATA_I[4:0];
                `TPP_IN1_ADDR: out_slot1_reg <= WDATA_I[4:0];
                default: ;
            endcase
        end
    end

    always @* begin
        rd_next = 8'h00;
        case (ADDR_I)
            `TPP_CTRL_ADDR: rd_next = ctrl_reg;
            `TPP_STAT_ADDR: rd_next = {3'h0, fsel_sync_reg[1], fmt_low_reg, fmt_valid_reg,
                fp_seen_reg, run};
            `TPP_OUT0_ADDR: rd_next = in0_data_reg;
            `TPP_OUT1_ADDR: rd_next = in1_data_reg;
            `TPP_IN0_ADDR: rd_next = {3'h0, out_slot0_reg};
            `TPP_IN1_ADDR: rd_next = {3'h0, out_slot1_reg};
            default: rd_next = 8'h00;
        endcase
    end

    // Registered outputs
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RDATA_O <= 8'h00;
            SOUT_O <= 1'b1;
            ROUT_O <= 1'b1;
            SOUT_OE_O <= 1'b0; // R02
            ROUT_OE_O <= 1'b0; // R02
            STANDBY_O <= 1'b1; // R10
            READY_O <= 1'b0;
        end else begin
            RDATA_O <= RD_I ? rd_next : 8'h00;
            SOUT_O <= tx0_sh_reg[7]; // R03
            ROUT_O <= tx1_sh_reg[7]; // R03
            SOUT_OE_O <= drive_en & fp_seen_reg; // R01
            ROUT_OE_O <= drive_en & fp_seen_reg; // R01
            STANDBY_O <= ~run;
            READY_O <= run; // R11
        end
    end
endmodule // tpp_port

// ### rtl/tpp_defines.vh
/*
 Constants for the TDM PCM port: control bit positions, reset values and frame timing.
 Assumes inclusion by its bare name from the port module.
*/
`ifndef TPP_DEFINES_VH
`define TPP_DEFINES_VH
`define TPP_CTRL_ADDR 4'h0
`define TPP_STAT_ADDR 4'h1
`define TPP_OUT0_ADDR 4'h2
`define TPP_OUT1_ADDR 4'h3
`define TPP_IN0_ADDR 4'h4
`define TPP_IN1_ADDR 4'h5
`define TPP_CTRL_ODE_BIT 6
`define TPP_CTRL_RST 8'h00
`define TPP_CHANNELS 32
`define TPP_BITS_PER_SLOT 8
`define TPP_CLKS_PER_BIT 2
`define TPP_INIT_CYCLES 16
`endif

// ### test/tpp_port_sva.sv
/* Checker for the TDM PCM port: drive gating, standby and init timing.
   Assumes binding to tpp_port with the same init length. */
`timescale 1ns/100ps
module tpp_port_sva #(
    parameter int INIT_CYCLES = 16
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic OUTPUT_DRIVE_ENABLE_I,
    input wire logic SOUT_OE_O,
    input wire logic ROUT_OE_O,
    input wire logic STANDBY_O,
    input wire logic READY_O
);
    logic [7:0] since_rst;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Cycles since reset release
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) since_rst <= 8'h00;
        else if (since_rst != 8'hff) since_rst <= since_rst + 8'h01;
    end
    a_oe_pair: assert property (SOUT_OE_O == ROUT_OE_O)
        else $error("output enables differ");
    a_oe_pin_low: assert property (!OUTPUT_DRIVE_ENABLE_I [*5] |-> !SOUT_OE_O)
        else $error("drive while pin low");
    a_standby_release: assert property ($rose(RST_N_I) |-> STANDBY_O && !READY_O)
        else $error("not in standby at release");
    a_standby_no_drive: assert property (STANDBY_O |-> !SOUT_OE_O && !ROUT_OE_O)
        else $error("drive during standby");
    a_init_not_early: assert property (READY_O |-> since_rst >= INIT_CYCLES)
        else $error("ready too early");
    a_init_not_late: assert property (!READY_O |-> since_rst <= INIT_CYCLES + 3)
        else $error("ready too late");
    a_ready_holds: assert property (READY_O |=> READY_O)
        else $error("ready dropped");
    a_ready_awake: assert property (READY_O |-> !STANDBY_O)
        else $error("ready in standby");
endmodule // tpp_port_sva
bind tpp_port tpp_port_sva #(.INIT_CYCLES(INIT_CYCLES)) i_sva(.CLK_I(CLK_I),
    .RST_N_I(RST_N_I), .OUTPUT_DRIVE_ENABLE_I(OUTPUT_DRIVE_ENABLE_I), .SOUT_OE_O(SOUT_OE_O),
    .ROUT_OE_O(ROUT_OE_O), .STANDBY_O(STANDBY_O), .READY_O(READY_O));

// ### test/tpp_far_end.sv
/* Far-end backplane model: bit clock, frame pulse, two input streams, output capture.
   Assumes 32 slots of 8 bits, two bit clocks a bit, MSB first. */
`timescale 1ns/100ps
module tpp_far_end #(
    parameter logic [4:0] SLOT = 5'h05,
    parameter logic [7:0] TX1 = 8'h3c,
    parameter logic [7:0] TX2 = 8'hc3
) (
    output logic bclk,
    output logic fp_n,
    output logic rin,
    output logic sin,
    input wire logic sout,
    input wire logic rout,
    output logic [7:0] got1,
    output logic [7:0] got2
);
    int c = 511;
    logic [7:0] s1, s2;
    // Start values set at declaration, so no false edge at time zero
    logic bclk_r = 1'b0, fp_r = 1'b1, rin_r = 1'b1, sin_r = 1'b1;
    assign {bclk, fp_n, rin, sin} = {bclk_r, fp_r, rin_r, sin_r};
    always #100 bclk_r = ~bclk_r;
    // New bit at the fall opening each bit period
    always @(negedge bclk_r) begin
        c = (c + 1) % 512;
        rin_r <= (c[8:4] == SLOT) ? TX1[7 - c[3:1]] : 1'b1;
        sin_r <= (c[8:4] == SLOT) ? TX2[7 - c[3:1]] : 1'b1;
    end
    // Pulse spans the fall that opens slot 0, idle high
    always @(posedge bclk_r) begin
        fp_r <= (c != 511);
        if (c[0] && c[8:4] == SLOT) begin
            s1 = {s1[6:0], sout};
            s2 = {s2[6:0], rout};
            if (c[3:0] == 4'hf) {got1, got2} <= {s1, s2};
        end
    end
endmodule // tpp_far_end

// ### test/testbench.sv
/* Testbench for the TDM PCM port: register tasks and frame-level checks.
   Assumes the far-end model and the checker are compiled with it. */
`timescale 1ns/100ps
module testbench;
    logic clk = 0, rst_n = 0, output_drive_enable = 0, fsel = 0, wr_s = 0, rd_s = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, v;
    wire bclk, fp_n, rin, sin, so, ro, so_oe, ro_oe, stby, rdy;
    wire [7:0] rdata, got1, got2;
    wire so_w = so_oe ? so : 1'bz;
    wire ro_w = ro_oe ? ro : 1'bz;
    int fails = 0, n_checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    tpp_port #(.INIT_CYCLES(4)) i_dut(.CLK_I(clk), .RST_N_I(rst_n), .SERIAL_BIT_CLOCK_IN_I(bclk),
        .FRAME_PULSE_IN_I(fp_n), .RIN_I(rin), .SIN_I(sin), .OUTPUT_DRIVE_ENABLE_I(output_drive_enable),
        .FREQ_SELECT_I(fsel), .SOUT_O(so), .SOUT_OE_O(so_oe), .ROUT_O(ro), .ROUT_OE_O(ro_oe),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
        .STANDBY_O(stby), .READY_O(rdy));
    tpp_far_end i_far(.bclk(bclk), .fp_n(fp_n), .rin(rin), .sin(sin), .sout(so_w),
        .rout(ro_w), .got1(got1), .got2(got2));
    task chk(input string nm, input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        {addr, wdata, wr_s} <= {a, d, 1'b1};
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [3:0] a);
        {addr, rd_s} <= {a, 1'b1};
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        chk("reset", {4'h0, stby, rdy, so_oe, ro_oe}, 8'h08);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clk);
        chk("ready", {6'h0, stby, rdy}, 8'h01);
        rd(4'h0);
        chk("ctrl", v, 8'h00);
        wr(4'h4, 8'h05);
        wr(4'h5, 8'h05);
        wr(4'h2, 8'ha5);
        wr(4'h3, 8'h5a);
        wr(4'h0, 8'h40);
        repeat (8200) @(posedge clk);
        chk("oe pin low", {6'h0, so_oe, ro_oe}, 8'h00);
        output_drive_enable <= 1'b1;
        repeat (8200) @(posedge clk);
        chk("oe on", {6'h0, so_oe, ro_oe}, 8'h03);
        chk("send out", got1, 8'ha5);
        chk("recv out", got2, 8'h5a);
        rd(4'h2);
        chk("rx port1", v, 8'h3c);
        rd(4'h3);
        chk("rx port2", v, 8'hc3);
        for (int f = 0; f < 2; f++) begin
            fsel <= f[0];
            repeat (4) @(posedge clk);
            rd(4'h1);
            chk("status", v & 8'h1e, {3'h0, f[0], 4'h6});
        end
        wr(4'h0, 8'h00);
        repeat (4) @(posedge clk);
        chk("oe bit low", {6'h0, so_oe, ro_oe}, 8'h00);
        wr(4'h0, 8'h40);
        repeat (4) @(posedge clk);
        chk("oe again", {6'h0, so_oe, ro_oe}, 8'h03);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset again", {4'h0, stby, rdy, so_oe, ro_oe}, 8'h08);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk);
        chk("ready again", {6'h0, stby, rdy}, 8'h01);
        rd(4'h0);
        chk("ctrl again", v, 8'h00);
        chk("oe after init", {6'h0, so_oe, ro_oe}, 8'h00);
        conclude();
    end
endmodule // testbench
